// >>> rtl/rtcw_top.sv
// Purpose: Time counters with hold-and-reload rewrite and rewrite error detection
// Assumes: half_tick is a one-cycle pulse in the clock domain, every 0.5 s
// Notes:   Software side is plain ports; no bus
module rtcw_top
	import rtcw_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        half_tick,
	input  wire logic        time_rewrite_hold,
	input  wire logic [7:0]  sec_reg,
	input  wire logic [7:0]  min_reg,
	input  wire logic [7:0]  hour_reg,
	input  wire logic [7:0]  day_reg,
	input  wire logic [7:0]  month_reg,
	input  wire logic [7:0]  year_reg,
	input  wire logic        cal_load,
	input  wire logic        flag_wr,
	input  wire logic        flag_wdata,
	input  wire logic        flag_rmw_rd,
	input  wire logic        rewrite_error_irq_enable,
	output logic [7:0]       sec_cnt,
	output logic [7:0]       min_cnt,
	output logic [7:0]       hour_cnt,
	output logic [7:0]       day_cnt,
	output logic [7:0]       month_cnt,
	output logic [7:0]       year_cnt,
	output logic             leap_year,
	output logic             rewrite_error_flag,
	output logic             flag_rd_data,
	output logic             rewrite_error_irq
);
	rtcw_cal_if cal ();

	// Rewrite control
	rtcw_state_t st_r, st_nxt;
	logic        half_ph_r, half_ph_nxt;
	logic        carry_seen_r, carry_seen_nxt;
	logic [1:0]  half_cnt_r, half_cnt_nxt;
	logic        sec_tick;
	logic        err_set;

	// Time counters
	logic [7:0]  sec_r, sec_nxt;
	logic [7:0]  min_r, min_nxt;
	logic [7:0]  hour_r, hour_nxt;

	// Error flag, read-back and request
	logic        err_r, err_nxt;
	logic        irq_r, irq_nxt;
	logic        rd_r, rd_nxt;

	// Calendar mirrors
	logic        leap_r;
	logic [7:0]  day_o_r, month_o_r, year_o_r;

	// Every second half carry is a 1-second carry
	assign sec_tick = half_tick & half_ph_r;

	// Rewrite control; the half phase runs on through a hold
	always_comb begin
		st_nxt         = st_r;
		half_ph_nxt    = half_tick ? ~half_ph_r : half_ph_r;
		carry_seen_nxt = carry_seen_r;
		half_cnt_nxt   = half_cnt_r;
		err_set        = 1'b0;
		unique case (st_r)
			RW_RUN: begin
				carry_seen_nxt = 1'b0;
				if (time_rewrite_hold) begin
					// A carry on the entry edge, or one owed by the reload, joins the hold
					st_nxt         = RW_HOLD;
					half_cnt_nxt   = {1'b0, half_tick};
					carry_seen_nxt = sec_tick | carry_seen_r;
				end
			end
			RW_HOLD: begin
				if (half_tick && half_cnt_r != HALF_ERR_CNT) begin
					half_cnt_nxt = half_cnt_r + 2'h1;
				end
				if (sec_tick) begin
					carry_seen_nxt = 1'b1;
				end
				if (!time_rewrite_hold) begin
					st_nxt = RW_RELOAD;
				end
			end
			RW_RELOAD: begin
				err_set        = (half_cnt_r == HALF_ERR_CNT);
				// A carry in the reload cycle is owed to the first run cycle
				carry_seen_nxt = sec_tick;
				st_nxt         = RW_RUN;
			end
			default: st_nxt = RW_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r         <= RW_RUN;
			half_ph_r    <= 1'b0;
			carry_seen_r <= 1'b0;
			half_cnt_r   <= 2'h0;
		end else begin
			st_r         <= st_nxt;
			half_ph_r    <= half_ph_nxt;
			carry_seen_r <= carry_seen_nxt;
			half_cnt_r   <= half_cnt_nxt;
		end
	end

	// Time counters; a carry owed by the reload is added in run
	always_comb begin
		sec_nxt       = sec_r;
		min_nxt       = min_r;
		hour_nxt      = hour_r;
		cal.day_carry = 1'b0;
		if (st_r == RW_RELOAD) begin
			// Reload, adding one if a carry was seen, on the same edge; min/hour taken from registers
			sec_nxt  = carry_seen_r ? rtcw_bcd_inc(sec_reg, SEC_MAX, RESET_SEC)
				: sec_reg;
			min_nxt  = min_reg;
			hour_nxt = hour_reg;
		end else if (st_r == RW_RUN && (sec_tick || carry_seen_r) && !time_rewrite_hold) begin
			sec_nxt = rtcw_bcd_inc(sec_r, SEC_MAX, RESET_SEC);
			if (sec_r >= SEC_MAX) begin
				min_nxt = rtcw_bcd_inc(min_r, MIN_MAX, RESET_MIN);
				if (min_r >= MIN_MAX) begin
					hour_nxt      = rtcw_bcd_inc(hour_r, HOUR_MAX, RESET_HOUR);
					cal.day_carry = (hour_r >= HOUR_MAX);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sec_r  <= RESET_SEC;
			min_r  <= RESET_MIN;
			hour_r <= RESET_HOUR;
		end else begin
			sec_r  <= sec_nxt;
			min_r  <= min_nxt;
			hour_r <= hour_nxt;
		end
	end

	// Error flag, its read-back value and request
	always_comb begin
		// Set beats a same-cycle software clear
		err_nxt = err_set | (err_r & ~(flag_wr & ~flag_wdata));
		irq_nxt = err_nxt & rewrite_error_irq_enable;
		rd_nxt  = flag_rmw_rd | err_nxt;
	end

	// Flag, read-back and request all move on one edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_r <= 1'b0;
			irq_r <= 1'b0;
			rd_r  <= 1'b0;
		end else begin
			err_r <= err_nxt;
			irq_r <= irq_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// Date registers load the calendar directly
	assign cal.load     = cal_load;
	assign cal.day_ld   = day_reg;
	assign cal.month_ld = month_reg;
	assign cal.year_ld  = year_reg;

	rtcw_calendar u_cal (
		.clock (clock),
		.rst_n (rst_n),
		.cal   (cal)
	);

	// Calendar values mirrored a cycle late so every output is a flop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			leap_r    <= 1'b0;
			day_o_r   <= RESET_DAY;
			month_o_r <= RESET_MONTH;
			year_o_r  <= RESET_YEAR;
		end else begin
			leap_r    <= cal.leap;
			day_o_r   <= cal.day;
			month_o_r <= cal.month;
			year_o_r  <= cal.year;
		end
	end

	assign sec_cnt            = sec_r;
	assign min_cnt            = min_r;
	assign hour_cnt           = hour_r;
	assign day_cnt            = day_o_r;
	assign month_cnt          = month_o_r;
	assign year_cnt           = year_o_r;
	assign leap_year          = leap_r;
	assign rewrite_error_flag = err_r;
	assign flag_rd_data       = rd_r;
	assign rewrite_error_irq  = irq_r;
endmodule : rtcw_top

// >>> rtl/rtcw_pkg.sv
// Purpose: Shared constants and types for the calendar and time rewrite block
// Assumes: BCD counters, two-digit year, one system clock
// Notes:   Half-second carry arrives as a one-cycle pulse from the generator
package rtcw_pkg;
	localparam int          BCD_W        = 8;
	localparam logic [7:0]  SEC_MAX      = 8'h59;
	localparam logic [7:0]  MIN_MAX      = 8'h59;
	localparam logic [7:0]  HOUR_MAX     = 8'h23;
	localparam logic [7:0]  MONTH_MAX    = 8'h12;
	localparam logic [7:0]  YEAR_MAX     = 8'h99;
	localparam logic [7:0]  DAY_FIRST    = 8'h01;
	localparam logic [7:0]  MONTH_FIRST  = 8'h01;
	localparam logic [7:0]  DAYS_LONG    = 8'h31;
	localparam logic [7:0]  DAYS_SHORT   = 8'h30;
	localparam logic [7:0]  DAYS_FEB_LEAP = 8'h29;
	localparam logic [7:0]  DAYS_FEB     = 8'h28;
	localparam logic [7:0]  MONTH_FEB    = 8'h02;
	localparam logic [1:0]  HALF_ERR_CNT = 2'h3;
	localparam logic [7:0]  RESET_SEC    = 8'h00;
	localparam logic [7:0]  RESET_MIN    = 8'h00;
	localparam logic [7:0]  RESET_HOUR   = 8'h00;
	localparam logic [7:0]  RESET_DAY    = 8'h01;
	localparam logic [7:0]  RESET_MONTH  = 8'h01;
	localparam logic [7:0]  RESET_YEAR   = 8'h00;

	typedef enum logic [1:0] {
		RW_RUN     = 2'b00,
		RW_HOLD    = 2'b01,
		RW_RELOAD  = 2'b10
	} rtcw_state_t;

	// BCD increment with wrap to a given first value
	function automatic logic [7:0] rtcw_bcd_inc(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		logic [7:0] r;
		r = v;
		if (v >= last) begin
			r = first;
		end else if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : rtcw_bcd_inc
endpackage : rtcw_pkg

// >>> rtl/rtcw_cal_if.sv
// Purpose: Carries the calendar state between the top and the calendar module
// Assumes: All byte-wide fields are BCD
// Notes:   day_carry and the load fields come from the top, the rest from the calendar
interface rtcw_cal_if;
	logic       day_carry;
	logic       load;
	logic [7:0] day_ld;
	logic [7:0] month_ld;
	logic [7:0] year_ld;
	logic [7:0] day;
	logic [7:0] month;
	logic [7:0] year;
	logic       leap;
	modport ctrl (output day_carry, output load, output day_ld, output month_ld,
		output year_ld, input day, input month, input year, input leap);
	modport cal  (input day_carry, input load, input day_ld, input month_ld,
		input year_ld, output day, output month, output year, output leap);
endinterface : rtcw_cal_if

// >>> rtl/rtcw_calendar.sv
// Purpose: Day, month and year counting with month lengths and leap years
// Assumes: Advances by one day per day_carry pulse
// Notes:   Year is two BCD digits, no century correction
module rtcw_calendar
	import rtcw_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	rtcw_cal_if.cal   cal
);
	logic [7:0] day_r,   day_nxt;
	logic [7:0] month_r, month_nxt;
	logic [7:0] year_r,  year_nxt;
	logic       leap;
	logic [7:0] last_day;

	// Multiple of four in BCD: tens even and units 0/4/8, or tens odd and 2/6
	always_comb begin
		leap = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6)
			: (year_r[3:0] == 4'h0 || year_r[3:0] == 4'h4 || year_r[3:0] == 4'h8);
	end

	always_comb begin
		unique case (month_r)
			8'h04, 8'h06, 8'h09, 8'h11: last_day = DAYS_SHORT;
			MONTH_FEB:                  last_day = leap ? DAYS_FEB_LEAP : DAYS_FEB;
			default:                    last_day = DAYS_LONG;
		endcase
	end

	always_comb begin
		day_nxt   = day_r;
		month_nxt = month_r;
		year_nxt  = year_r;
		if (cal.load) begin
			day_nxt   = cal.day_ld;
			month_nxt = cal.month_ld;
			year_nxt  = cal.year_ld;
		end else if (cal.day_carry) begin
			day_nxt = rtcw_bcd_inc(day_r, last_day, DAY_FIRST);
			if (day_r >= last_day) begin
				month_nxt = rtcw_bcd_inc(month_r, MONTH_MAX, MONTH_FIRST);
				if (month_r >= MONTH_MAX) begin
					year_nxt = rtcw_bcd_inc(year_r, YEAR_MAX, RESET_YEAR);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			day_r   <= RESET_DAY;
			month_r <= RESET_MONTH;
			year_r  <= RESET_YEAR;
		end else begin
			day_r   <= day_nxt;
			month_r <= month_nxt;
			year_r  <= year_nxt;
		end
	end

	assign cal.day   = day_r;
	assign cal.month = month_r;
	assign cal.year  = year_r;
	assign cal.leap  = leap;
endmodule : rtcw_calendar

// >>> testbench/rtcw_top_props.sv
// Purpose: Concurrent checks on the rewrite flag, its read value and the hold
// Assumes: Flag and request land on the edge after the one that sees hold low
// Notes:   Bound to every rtcw_top instance
module rtcw_props (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       time_rewrite_hold,
	input wire logic       flag_wr,
	input wire logic       flag_wdata,
	input wire logic       flag_rmw_rd,
	input wire logic       rewrite_error_irq_enable,
	input wire logic [7:0] sec_cnt,
	input wire logic       rewrite_error_flag,
	input wire logic       flag_rd_data,
	input wire logic       rewrite_error_irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	irq_gate_a: assert property (rewrite_error_irq ==
		(rewrite_error_flag && $past(rewrite_error_irq_enable))) else $error("irq wrong");
	flag_cause_a: assert property ($rose(rewrite_error_flag) |->
		!$past(time_rewrite_hold, 2) && $past(time_rewrite_hold, 3)) else $error("flag cause");
	flag_clear_a: assert property (flag_wr && !flag_wdata
		&& !(!$past(time_rewrite_hold) && $past(time_rewrite_hold, 2))
		|=> !rewrite_error_flag) else $error("flag not cleared");
	write_one_a: assert property (flag_wr && flag_wdata && rewrite_error_flag
		|=> rewrite_error_flag) else $error("write one changed flag");
	flag_sticky_a: assert property (rewrite_error_flag && !flag_wr |=> rewrite_error_flag)
		else $error("flag dropped");
	rmw_read_a: assert property (flag_rmw_rd |=> flag_rd_data) else $error("rmw read");
	plain_read_a: assert property (!$past(flag_rmw_rd) |-> flag_rd_data == rewrite_error_flag)
		else $error("read value");
	hold_freeze_a: assert property (time_rewrite_hold && $past(time_rewrite_hold)
		|=> $stable(sec_cnt)) else $error("seconds moved in hold");
endmodule : rtcw_props

bind rtcw_top rtcw_props rtcw_props_i (.clock(clock), .rst_n(rst_n),
	.time_rewrite_hold(time_rewrite_hold), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
	.flag_rmw_rd(flag_rmw_rd), .rewrite_error_irq_enable(rewrite_error_irq_enable),
	.sec_cnt(sec_cnt), .rewrite_error_flag(rewrite_error_flag),
	.flag_rd_data(flag_rd_data), .rewrite_error_irq(rewrite_error_irq));

// >>> testbench/rtcw_top_tb.sv
// Purpose: Self-checking bench for the calendar and time rewrite block
// Assumes: Bench owns the half-second pulse and the software side
// Notes:   Seconds expectations track the half-second phase in ph
module rtcw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       ht = 1'b0;
	logic       hold = 1'b0;
	logic [7:0] s_r = 8'h00;
	logic [7:0] m_r = 8'h00;
	logic [7:0] d_r = 8'h01;
	logic [7:0] mo_r = 8'h01;
	logic [7:0] y_r = 8'h00;
	logic       ld = 1'b0;
	logic       wr_en = 1'b0;
	logic       wd = 1'b0;
	logic       rmw = 1'b0;
	logic       en = 1'b0;
	logic [7:0] sec, mn, hr, day, mon, yr;
	logic       leap, flag, rd, irq;
	logic       ph = 1'b0;
	int         err_count = 0;
	int         n_checks = 0;
	always #2.5 clock = ~clock;
	rtcw_top rtcw_top_i (.clock(clock), .rst_n(rst_n), .half_tick(ht),
		.time_rewrite_hold(hold), .sec_reg(s_r), .min_reg(m_r), .hour_reg(8'h23),
		.day_reg(d_r), .month_reg(mo_r), .year_reg(y_r), .cal_load(ld), .flag_wr(wr_en),
		.flag_wdata(wd), .flag_rmw_rd(rmw), .rewrite_error_irq_enable(en), .sec_cnt(sec),
		.min_cnt(mn), .hour_cnt(hr), .day_cnt(day), .month_cnt(mon), .year_cnt(yr),
		.leap_year(leap), .rewrite_error_flag(flag), .flag_rd_data(rd), .rewrite_error_irq(irq));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic pulse();
		@(posedge clock) ht <= 1'b1;
		@(posedge clock) ht <= 1'b0;
		ph = ~ph;
	endtask : pulse
	task automatic wr(input logic v);
		@(posedge clock) begin
			wr_en <= 1'b1;
			wd <= v;
		end
		@(posedge clock) wr_en <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : wr
	task automatic t_hold(input logic [7:0] s, input logic [7:0] m, input int n);
		logic c;
		c = 1'b0;
		@(posedge clock) begin
			hold <= 1'b1;
			s_r <= s;
			m_r <= m;
		end
		repeat (2) @(posedge clock);
		repeat (n) begin
			c = c | ph;
			pulse();
		end
		@(posedge clock) hold <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk("sec", s + 8'(c), sec);
		chk("min", m, mn);
		chk("hour", 8'h23, hr);
		chk("flag", 8'(n > 2), flag);
		$display("hold test %0d done", n);
	endtask : t_hold
	task automatic t_cal(input logic [7:0] y, mo, d, ed, em, ey, input logic lp);
		@(posedge clock) begin
			y_r <= y;
			mo_r <= mo;
			d_r <= d;
			ld <= 1'b1;
		end
		@(posedge clock) ld <= 1'b0;
		t_hold(8'h59, 8'h59, 0);
		chk("leap", 8'(lp), leap);
		if (!ph) pulse();
		pulse();
		repeat (4) @(posedge clock);
		#1;
		chk("day", ed, day);
		chk("month", em, mon);
		chk("year", ey, yr);
		$display("calendar test done");
	endtask : t_cal
	task automatic t_flag();
		chk("irq", 8'h00, irq);
		@(posedge clock) en <= 1'b1;
		wr(1'b1);
		chk("flag", 8'h01, flag);
		chk("irq", 8'h01, irq);
		@(posedge clock) rmw <= 1'b1;
		wr(1'b0);
		chk("rd", 8'h01, rd);
		chk("flag", 8'h00, flag);
		chk("irq", 8'h00, irq);
		@(posedge clock) rmw <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("rd", 8'h00, rd);
		$display("flag test done");
	endtask : t_flag
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_cal(8'h04, 8'h02, 8'h28, 8'h29, 8'h02, 8'h04, 1'b1);
		t_cal(8'h03, 8'h02, 8'h28, 8'h01, 8'h03, 8'h03, 1'b0);
		t_cal(8'h00, 8'h02, 8'h29, 8'h01, 8'h03, 8'h00, 1'b1);
		t_cal(8'h98, 8'h04, 8'h30, 8'h01, 8'h05, 8'h98, 1'b0);
		t_cal(8'h96, 8'h07, 8'h30, 8'h31, 8'h07, 8'h96, 1'b1);
		t_cal(8'h99, 8'h12, 8'h31, 8'h01, 8'h01, 8'h00, 1'b0);
		t_hold(8'h06, 8'h05, 1);
		t_hold(8'h06, 8'h05, 2);
		t_hold(8'h06, 8'h05, 3);
		t_flag();
		t_hold(8'h06, 8'h05, 1);
		t_hold(8'h16, 8'h05, 6);
		wrap_up();
	end
endmodule : rtcw_top_tb
